/* verilog/sup_pkg.sv */
// Purpose: shared constants and types of the LED driver supervisor
// Assumes: 25 MHz clock, comparator levels arrive as digital flags
// Notes:   times kept in own unit, cycle counts derived here
// Function
// [R1] Zero-cross falling below level clocks valleys
// [R2] Time-out makes substitute valley clocks
// [R3] Aux timer fault unless zero-cross rises
// [R4] Aux short stops; recover or latch
// [R5] First valley low line, second high line
// [R6] Foldback adds extra valleys before pulse
// [R7] Low line after blanked low level
// [R8] High line at once above level
// [R9] Current limit ends gate pulse immediately
// [R10] Four over-stop periods give winding fault
// [R11] Short blanking shorter than limit blanking
// [R12] Supply over-voltage stops, auto-recovers always
// [R13] Shutdown pin over-voltage faults per variant
// [R14] Foldback lowers current reference to half
// [R15] Over-temperature blocks until release level
// [R16] Latched over-temperature held until reset
// [R17] Over-temperature ignored during start-up blanking
// [R18] Blanked low line sense gives brown-out
// [R19] Brown-out exits on line and supply
// [R20] Brown-out recovery uses start-up consumption
// [R21] Die over-temperature stops until released
// [R22] Recovery delay then supply start level
// [R23] Latched fault holds until supply reset
// [R24] Static variant input picks latch mode
// [R25] One clock, comparators synchronised first
// [R26] Undervoltage reset clears all state
package sup_pkg;
  localparam int CLK_MHZ = 25;
  localparam int TMO_NS = 6500;
  localparam int TMO_CYC = (TMO_NS * CLK_MHZ + 999) / 1000;
  localparam int LIM_BLANK_NS = 400;
  localparam int LIM_BLANK_CYC = (LIM_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_BLANK_NS = 120;
  localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int AUX_SHORT_MS = 90;
  localparam int AUX_SHORT_CYC = AUX_SHORT_MS * CLK_MHZ * 1000;
  localparam int LINE_BLANK_MS = 25;
  localparam int LINE_BLANK_CYC = LINE_BLANK_MS * CLK_MHZ * 1000;
  localparam int OTP_BLANK_US = 250;
  localparam int OTP_BLANK_CYC = OTP_BLANK_US * CLK_MHZ;
  localparam int RECOVER_S = 4;
  localparam int RECOVER_CYC = RECOVER_S * CLK_MHZ * 1000000;
  localparam int TMR_W = 27;
  localparam logic [3:0] LL_VALLEYS = 4'h1;
  localparam logic [3:0] HL_VALLEYS = 4'h2;
  localparam logic [2:0] WSHORT_LAST = 3'h3;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RST = 1'h1;
  typedef struct packed {
    logic zcd_low;
    logic zcd_short_ok;
    logic vs_below_ll;
    logic vs_above_hl;
    logic vs_below_bo;
    logic vs_above_bo;
    logic cs_ilim;
    logic cs_setpoint;
    logic cs_stop;
    logic vcc_ovp;
    logic vcc_on;
    logic sd_ovp;
    logic sd_fold;
    logic sd_fold_deep;
    logic sd_otp;
    logic sd_otp_rel;
    logic die_hot;
  } cmp_t;
  typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_RECOVER, ST_LATCH} sup_state_t;
endpackage

/* verilog/sync2.sv */
// Purpose: two flip-flop synchroniser for a vector of levels
// Assumes: each bit is an independent slow level
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // Two stages per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      meta_q[i] <= rst_n_i ? d_i[i] : 1'h0;
      q_o[i]    <= rst_n_i ? meta_q[i] : 1'h0;
    end
  end
endmodule

/* verilog/dwell_timer.sv */
// Purpose: counts cycles a condition holds, saturates at limit
// Assumes: limit is static
// Notes:   done is a level while count sits at limit
`timescale 1ns/1ps
module dwell_timer #(
  parameter int W = 27
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic [W-1:0] limit_i,
  input  wire logic         run_i,
  output logic              done_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Count while run, clear otherwise
  assign done_o = (cnt_q == limit_i);
  assign cnt_d  = !run_i ? '0 : done_o ? cnt_q : cnt_q + 1'b1;

  always_ff @(posedge clk_i) begin
    cnt_q <= rst_n_i ? cnt_d : '0;
  end
endmodule

/* verilog/led_supervisor.sv */
// Purpose: valley timing, line range, gate pulse and fault control
// Assumes: comparator flags are asynchronous digital levels
// Notes:   AHB-Lite slave, zero wait states, OKAY always
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module led_supervisor #(
  parameter int AUX_CYC  = sup_pkg::AUX_SHORT_CYC,
  parameter int LINE_CYC = sup_pkg::LINE_BLANK_CYC,
  parameter int OTPB_CYC = sup_pkg::OTP_BLANK_CYC,
  parameter int REC_CYC  = sup_pkg::RECOVER_CYC
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  // Variant and comparators
  input  wire logic          latch_variant_i,
  input  wire sup_pkg::cmp_t cmp_i,
  // AHB-Lite slave
  input  wire logic          hsel_i,
  input  wire logic [31:0]   haddr_i,
  input  wire logic [1:0]    htrans_i,
  input  wire logic          hwrite_i,
  input  wire logic [2:0]    hsize_i,
  input  wire logic [31:0]   hwdata_i,
  input  wire logic          hready_i,
  output logic      [31:0]   hrdata_o,
  output logic               hreadyout_o,
  output logic               hresp_o,
  // Power stage
  output logic               gate_o,
  output logic               startup_consumption_o,
  output logic      [1:0]    iref_scale_o,
  output logic               fault_off_o
);
  localparam int TW = sup_pkg::TMR_W;

  sup_pkg::cmp_t      c;
  sup_pkg::sup_state_t state_q;
  sup_pkg::sup_state_t state_d;
  logic var_latch;
  logic zcd_prev_q;
  logic tmo_hit;
  logic valley_clk;
  logic aux_hit;
  logic ll_done;
  logic bo_done;
  logic otp_armed;
  logic rec_done;
  logic low_line_q;
  logic bo_q;
  logic otp_hold_q;
  logic gate_q;
  logic [3:0] vcnt_q;
  logic [3:0] leb_q;
  logic stop_seen_q;
  logic [2:0] wcnt_q;
  logic ctrl_en_q;
  logic [4:0] cause_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic startup_q;
  logic [1:0] iref_q;
  logic fault_off_q;

  // Valleys needed for the next pulse
  function automatic logic [3:0] need_valleys(input logic ll,
                                              input logic fold,
                                              input logic deep);
    logic [3:0] n;
    n = ll ? sup_pkg::LL_VALLEYS : sup_pkg::HL_VALLEYS;
    n = n + {3'h0, fold} + {3'h0, deep & fold};
    return n;
  endfunction

  // [R25] synchronise comparator and variant inputs
  sync2 #(.W($bits(sup_pkg::cmp_t) + 1)) u_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({latch_variant_i, cmp_i}),
    .q_o     ({var_latch, c})
  );

  // [R1] falling edge of zero-cross
  always_ff @(posedge sys_clk_i) begin
    zcd_prev_q <= rst_n_i ? c.zcd_low : 1'h0;
  end

  // [R2] periodic substitute valley
  dwell_timer #(.W(TW)) u_tmo (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (TW'(sup_pkg::TMO_CYC)),
    .run_i   (c.zcd_low & ~tmo_hit),
    .done_o  (tmo_hit)
  );

  // [R1] valley clock source
  assign valley_clk = (c.zcd_low & ~zcd_prev_q) | tmo_hit;

  // [R3] aux short timer while running
  dwell_timer #(.W(TW)) u_aux (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (TW'(AUX_CYC)),
    .run_i   ((state_q == sup_pkg::ST_RUN) & ~c.zcd_short_ok & ~aux_hit),
    .done_o  (aux_hit)
  );

  // [R7] low line blanking
  dwell_timer #(.W(TW)) u_ll (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (TW'(LINE_CYC)),
    .run_i   (c.vs_below_ll),
    .done_o  (ll_done)
  );

  // [R18] brown-out blanking
  dwell_timer #(.W(TW)) u_bo (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (TW'(LINE_CYC)),
    .run_i   (c.vs_below_bo),
    .done_o  (bo_done)
  );

  // [R17] arm temperature check after start
  dwell_timer #(.W(TW)) u_otpb (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (TW'(OTPB_CYC)),
    .run_i   (c.vcc_on),
    .done_o  (otp_armed)
  );

  // [R22] recovery delay
  dwell_timer #(.W(TW)) u_rec (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (TW'(REC_CYC)),
    .run_i   (state_q == sup_pkg::ST_RECOVER),
    .done_o  (rec_done)
  );

  // Fault and gate decode
  logic otp_trip;
  logic wshort_hit;
  logic cfg_fault;
  logic run_ok;
  logic gate_start;
  logic gate_end;
  logic stop_now;
  logic lim_open;
  logic short_open;
  // [R15] over-temperature trip once armed
  assign otp_trip   = otp_armed & c.sd_otp;
  // [R11] short comparator opens earlier
  assign short_open = leb_q >= 4'(sup_pkg::SHORT_BLANK_CYC);
  assign lim_open   = leb_q >= 4'(sup_pkg::LIM_BLANK_CYC);
  assign stop_now   = gate_q & short_open & c.cs_stop;
  // [R10] fourth over-stop period
  assign wshort_hit = gate_end & (stop_seen_q | stop_now) &
                      (wcnt_q == sup_pkg::WSHORT_LAST);
  // [R13] per-variant faults
  assign cfg_fault  = aux_hit | wshort_hit | c.sd_ovp | otp_trip;
  // [R18] [R21] blocking conditions
  assign run_ok     = (state_q == sup_pkg::ST_RUN) & ~bo_q & ~otp_hold_q &
                      ~c.die_hot & ~c.vcc_ovp & ~cfg_fault & ctrl_en_q;
  // [R5] [R6] pulse on the chosen valley
  assign gate_start = ~gate_q & run_ok & valley_clk &
                      ((vcnt_q + 4'h1) >= need_valleys(low_line_q, c.sd_fold,
                                                       c.sd_fold_deep));
  // [R9] limit or setpoint ends the pulse
  assign gate_end   = gate_q & (~run_ok | (lim_open & c.cs_ilim) |
                                (lim_open & c.cs_setpoint));

  // Fault state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sup_pkg::ST_WAIT: begin
        // [R19] [R22] resume on supply start level
        if (c.vcc_on & ~bo_q & ~otp_hold_q & ~c.die_hot) begin
          state_d = sup_pkg::ST_RUN;
        end
      end
      sup_pkg::ST_RUN: begin
        // [R24] variant picks latch or recovery
        if (cfg_fault & var_latch) begin
          state_d = sup_pkg::ST_LATCH;
        // [R4] [R12] auto-recovery entry
        end else if (cfg_fault | c.vcc_ovp) begin
          state_d = sup_pkg::ST_RECOVER;
        end
      end
      sup_pkg::ST_RECOVER: begin
        if (rec_done) begin
          state_d = sup_pkg::ST_WAIT;
        end
      end
      // [R16] [R23] only reset leaves latch
      sup_pkg::ST_LATCH: state_d = sup_pkg::ST_LATCH;
    endcase
  end

  // [R26] state cleared by reset
  always_ff @(posedge sys_clk_i) begin
    state_q <= rst_n_i ? state_d : sup_pkg::ST_WAIT;
  end

  // Line range and brown-out flags
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      low_line_q <= 1'h0;
      bo_q       <= 1'h0;
    end else begin
      // [R8] high line wins at once
      low_line_q <= c.vs_above_hl ? 1'h0 : ((ll_done & c.vs_below_ll) | low_line_q);
      // [R19] exit brown-out on line and supply
      bo_q       <= bo_done | (bo_q & ~(c.vs_above_bo & c.vcc_on));
    end
  end

  // [R15] over-temperature hold with release
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      otp_hold_q <= 1'h0;
    end else begin
      otp_hold_q <= otp_trip | (otp_hold_q & ~c.sd_otp_rel);
    end
  end

  // Gate pulse, blanking and valley count
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gate_q      <= 1'h0;
      leb_q       <= 4'h0;
      vcnt_q      <= 4'h0;
      stop_seen_q <= 1'h0;
    end else begin
      gate_q      <= gate_start | (gate_q & ~gate_end);
      leb_q       <= (gate_q & ~&leb_q) ? leb_q + 4'h1 :
                     (gate_q ? leb_q : 4'h0);
      vcnt_q      <= (gate_q | gate_start | ~run_ok) ? 4'h0 :
                     (valley_clk ? vcnt_q + 4'h1 : vcnt_q);
      stop_seen_q <= gate_start ? 1'h0 : (stop_seen_q | stop_now);
    end
  end

  // [R10] consecutive over-stop periods
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || wshort_hit) begin
      wcnt_q <= 3'h0;
    end else if (gate_end) begin
      wcnt_q <= (stop_seen_q | stop_now) ? wcnt_q + 3'h1 : 3'h0;
    end
  end

  // Registered block outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      startup_q   <= 1'h0;
      iref_q      <= 2'h0;
      fault_off_q <= 1'h1;
      cause_q     <= 5'h00;
    end else begin
      // [R20] low draw while supply recharges
      startup_q   <= bo_q | (state_q == sup_pkg::ST_WAIT);
      // [R14] reference reduced, half at stop level
      iref_q      <= c.sd_fold_deep ? 2'h2 : (c.sd_fold ? 2'h1 : 2'h0);
      fault_off_q <= ~run_ok;
      cause_q     <= cause_q | ({5{state_q == sup_pkg::ST_RUN}} &
                     {c.vcc_ovp, otp_trip, c.sd_ovp, wshort_hit, aux_hit});
    end
  end

  // Bus address phase decode
  logic       bus_sel;
  logic [7:0] bus_addr;
  logic [31:0] rd_word;
  assign bus_sel  = hsel_i & hready_i & htrans_i[1];
  assign bus_addr = haddr_i[7:0];
  assign rd_word  =
    (bus_addr == sup_pkg::ADDR_STATUS && haddr_i[31:8] == 24'h0) ?
      {19'h0, cause_q, state_q, iref_q, otp_hold_q, bo_q,
       low_line_q, gate_q} :
    (bus_addr == sup_pkg::ADDR_CTRL && haddr_i[31:8] == 24'h0) ?
      {31'h0, ctrl_en_q} : 32'h0;

  // Bus slave registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_pend_q   <= 1'h0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0;
      hreadyout_q <= 1'h1;
      ctrl_en_q   <= sup_pkg::CTRL_RST;
    end else begin
      wr_pend_q   <= bus_sel & hwrite_i & (haddr_i[31:8] == 24'h0);
      wr_addr_q   <= bus_addr;
      hrdata_q    <= (bus_sel & ~hwrite_i) ? rd_word : hrdata_q;
      hreadyout_q <= 1'h1;
      if (wr_pend_q && wr_addr_q == sup_pkg::ADDR_CTRL) begin
        ctrl_en_q <= hwdata_i[sup_pkg::CTRL_EN_BIT];
      end
    end
  end

  assign hrdata_o              = hrdata_q;
  assign hreadyout_o           = hreadyout_q;
  assign hresp_o               = 1'h0 & hsize_i[0];
  assign gate_o                = gate_q;
  assign startup_consumption_o = startup_q;
  assign iref_scale_o          = iref_q;
  assign fault_off_o           = fault_off_q;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [8:0] low_run_q;
  always_ff @(posedge sys_clk_i) begin
    low_run_q <= (!rst_n_i || !c.zcd_low || tmo_hit) ? 9'h000 :
                 (&low_run_q ? low_run_q : low_run_q + 9'h001);
  end

  a_tmo_spacing: assert property ( // [R2]
    tmo_hit |-> (low_run_q == 9'(sup_pkg::TMO_CYC)))
    else $error("valley time-out at wrong count");
  a_ilim_cut: assert property ( // [R9]
    gate_q && lim_open && c.cs_ilim |=> !gate_q)
    else $error("gate not ended by current limit");
  a_hl_at_once: assert property ( // [R8]
    c.vs_above_hl |=> !low_line_q)
    else $error("high line not taken at once");
  a_ll_after_blank: assert property ( // [R7]
    $rose(low_line_q) |-> $past(ll_done) && $past(c.vs_below_ll))
    else $error("low line without blanking");
  a_latch_entry: assert property ( // [R24]
    state_q == sup_pkg::ST_RUN && cfg_fault && var_latch
    |=> state_q == sup_pkg::ST_LATCH)
    else $error("latching variant did not latch");
  a_latch_holds: assert property ( // [R23]
    state_q == sup_pkg::ST_LATCH |=> state_q == sup_pkg::ST_LATCH ##1 !gate_q)
    else $error("latched fault released or pulsing");
  a_ovp_recover: assert property ( // [R12]
    state_q == sup_pkg::ST_RUN && c.vcc_ovp && !cfg_fault
    |=> state_q == sup_pkg::ST_RECOVER ##1 !gate_q)
    else $error("supply over-voltage not recovered");
  a_recover_wait: assert property ( // [R22]
    $fell(state_q == sup_pkg::ST_RECOVER) |-> $past(rec_done) &&
    state_q == sup_pkg::ST_WAIT)
    else $error("recovery left before delay");
  a_wshort_fourth: assert property ( // [R10]
    wshort_hit |-> wcnt_q == 3'h3 && state_q == sup_pkg::ST_RUN)
    else $error("winding fault not on fourth period");
  a_gate_blocked: assert property ( // [R21]
    c.die_hot |=> !gate_q)
    else $error("gate during die over-temperature");

  c_gate_pulse: cover property ($rose(gate_q) ##[1:50] $fell(gate_q));
  c_latch: cover property ($rose(state_q == sup_pkg::ST_LATCH));
  c_resume: cover property ($fell(state_q == sup_pkg::ST_RECOVER));
  c_low_line: cover property ($rose(low_line_q));
endmodule

/* tb/power_stage_model.sv */
// Purpose: far-side model of gate, aux winding and sense comparators
// Assumes: ringing period of 8 cycles, current limit after 12 on cycles
// Notes:   all outputs registered, so they change just after an edge
`timescale 1ns/1ps
module power_stage_model (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Levels and modes from the bench
  input  wire sup_pkg::cmp_t lvl_i,
  input  wire logic          ring_i,
  input  wire logic          stop_i,
  // Gate side
  input  wire logic          gate_i,
  output sup_pkg::cmp_t      cmp_o,
  output logic [3:0]         valleys_o
);
  logic [7:0]    off_q;
  logic [7:0]    on_q;
  sup_pkg::cmp_t c;
  // Drain ringing after turn-off, current trips while on
  always_comb begin
    c = lvl_i;
    if (ring_i) begin
      c.zcd_low      = !gate_i && off_q[2];
      c.zcd_short_ok = !gate_i && !off_q[2];
    end
    c.cs_ilim = gate_i && (on_q >= 8'h0C);
    c.cs_stop = stop_i && gate_i && (on_q >= 8'h04) && (on_q <= 8'h06); // Short spike only
  end
  // Timers and count of valleys seen since last pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      off_q     <= 8'h00;
      on_q      <= 8'h00;
      cmp_o     <= lvl_i;
      valleys_o <= 4'h0;
    end else begin
      off_q <= gate_i ? 8'h00 : off_q + 8'h01;
      on_q  <= gate_i ? on_q + 8'h01 : 8'h00;
      cmp_o <= c;
      if (gate_i && on_q == 8'h01)
        valleys_o <= 4'h0;
      else if (c.zcd_low && !cmp_o.zcd_low)
        valleys_o <= valleys_o + 4'h1;
    end
  end
endmodule

/* tb/led_driver_valley_and_fault_sequencer_tb_top.sv */
// Purpose: self-checking bench of the LED driver supervisor
// Assumes: shortened timers AUX 50, LINE 40, OTPB 20, REC 100 cycles
// Notes:   comparator levels reach the block via the stage model
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) begin \
      n_fail++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module led_driver_valley_and_fault_sequencer_tb_top;
  localparam sup_pkg::cmp_t BASE = '{vs_above_hl: 1'b1, vs_above_bo: 1'b1, vcc_on: 1'b1,
                                     sd_otp_rel: 1'b1, zcd_short_ok: 1'b1, default: 1'b0};
  logic          sys_clk_i;
  logic          rst_n_i;
  logic          latch_variant_i;
  logic          ring;
  logic          stop;
  logic          hsel;
  logic          hwrite;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   haddr;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic [31:0]   s;
  logic          hready;
  logic          hresp;
  logic          gate;
  logic          sc;
  logic          foff;
  logic [1:0]    iref;
  logic [3:0]    valleys;
  sup_pkg::cmp_t lvl;
  sup_pkg::cmp_t cmp;
  sup_pkg::cmp_t c;
  int            n_fail;
  int            tests_run;
  int            hits;
  int            w;

  // Block under test with short timers
  led_supervisor #(.AUX_CYC(50), .LINE_CYC(40), .OTPB_CYC(20), .REC_CYC(100)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .latch_variant_i(latch_variant_i), .cmp_i(cmp),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .gate_o(gate), .startup_consumption_o(sc), .iref_scale_o(iref),
    .fault_off_o(foff));

  // Power stage on the far side
  power_stage_model i_stage (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lvl_i(lvl), .ring_i(ring), .stop_i(stop),
    .gate_i(gate), .cmp_o(cmp), .valleys_o(valleys));

  // 25 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard
  initial begin
    #4000000;
    n_fail++;
    print_verdict();
  end

  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Single word transfer, address then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge sys_clk_i);
    for (i = 0; i < 20 && hready !== 1'b1; i++) @(posedge sys_clk_i);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk_i);
    for (i = 0; i < 20 && hready !== 1'b1; i++) @(posedge sys_clk_i);
    rd = hrdata;
    if (hready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task automatic st();
    bus(1'b0, sup_pkg::ADDR_STATUS, 32'h00000000, s);
  endtask

  task automatic wait_gate(input logic v);
    int i;
    for (i = 0; i < 3000 && gate !== v; i++) @(posedge sys_clk_i);
    if (gate !== v) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // Counts gate-high samples over n cycles
  task automatic quiet(input int n);
    hits = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      if (gate !== 1'b0) hits++;
    end
  endtask

  task automatic pulses(input logic sp, input int n);
    stop <= sp;
    repeat (n) begin
      wait_gate(1'b1);
      wait_gate(1'b0);
    end
  endtask

  task automatic do_reset(input logic lat);
    @(posedge sys_clk_i);
    rst_n_i         <= 1'b0;
    latch_variant_i <= lat;
    cyc(4);
    `CHK({foff, gate}, 2'h2)
    rst_n_i <= 1'b1;
    st();
    `CHK(s[12:8], 5'h00)
  endtask

  // Reset values, map, enable bit
  task automatic t_regs();
    `CHK(s, 32'h00000000)
    bus(1'b0, sup_pkg::ADDR_CTRL, 32'h00000000, s);
    `CHK(s, 32'h00000001)
    bus(1'b1, 8'h08, 32'hFFFFFFFF, s);
    bus(1'b1, sup_pkg::ADDR_STATUS, 32'hFFFFFFFF, s);
    bus(1'b0, 8'h08, 32'h00000000, s);
    `CHK({hresp, s}, 33'h000000000)
    st();
    `CHK(s[7:0], 8'h00)
    bus(1'b1, sup_pkg::ADDR_CTRL, 32'h00000000, s);
    lvl.vcc_on <= 1'b1;
    quiet(80);
    `CHK(hits, 0)
    st();
    `CHK(s[7:6], 2'h1)
    bus(1'b1, sup_pkg::ADDR_CTRL, 32'h00000001, s);
    wait_gate(1'b1);
  endtask

  task automatic t_lines();
    lvl.vs_above_hl <= 1'b0;
    lvl.vs_below_ll <= 1'b1;
    cyc(30);
    st();
    `CHK(s[1], 1'b0)
    cyc(20);
    st();
    `CHK(s[1], 1'b1)
    pulses(1'b0, 1);
    wait_gate(1'b1);
    `CHK(valleys, 4'h1)
    lvl.vs_above_hl <= 1'b1;
    lvl.vs_below_ll <= 1'b0;
    cyc(4);
    st();
    `CHK(s[1], 1'b0)
    for (int k = 0; k < 3; k++) begin
      lvl.sd_fold      <= (k > 0);
      lvl.sd_fold_deep <= (k > 1);
      pulses(1'b0, 2);
      wait_gate(1'b1);
      `CHK(valleys, 4'(2 + k))
      `CHK(iref, 2'(k))
    end
    lvl.sd_fold      <= 1'b0;
    lvl.sd_fold_deep <= 1'b0;
  endtask

  task automatic t_ilim();
    pulses(1'b0, 1);
    wait_gate(1'b1);
    for (w = 0; w < 40 && gate === 1'b1; w++) @(posedge sys_clk_i);
    `CHK(w >= 13 && w <= 17, 1'b1)
    lvl.cs_setpoint <= 1'b1;
    pulses(1'b0, 1);
    wait_gate(1'b1);
    for (w = 0; w < 40 && gate === 1'b1; w++) @(posedge sys_clk_i);
    `CHK(w, sup_pkg::LIM_BLANK_CYC + 1)
    lvl.cs_setpoint <= 1'b0;
    ring          <= 1'b0;
    lvl.zcd_low   <= 1'b1;
    pulses(1'b0, 2);
    wait_gate(1'b1);
    `CHK(valleys, 4'h0)
  endtask

  task automatic t_aux();
    lvl.zcd_short_ok <= 1'b0;
    cyc(30);
    st();
    `CHK(s[8], 1'b0)
    cyc(30);
    st();
    `CHK({s[8], s[7:6]}, 3'h6)
    ring             <= 1'b1;
    lvl.zcd_low      <= 1'b0;
    lvl.zcd_short_ok <= 1'b1;
    quiet(60);
    `CHK(hits, 0)
    wait_gate(1'b1);
  endtask

  task automatic t_wshort();
    wait_gate(1'b0);
    pulses(1'b1, 3);
    pulses(1'b0, 1);
    pulses(1'b1, 3);
    st();
    `CHK(s[9], 1'b0)
    pulses(1'b1, 1);
    stop <= 1'b0;
    cyc(8);
    st();
    `CHK({s[9], s[7:6]}, 3'h6)
    wait_gate(1'b1);
  endtask

  task automatic t_block();
    lvl.vs_below_bo <= 1'b1;
    lvl.vs_above_bo <= 1'b0;
    cyc(30);
    st();
    `CHK(s[2], 1'b0)
    cyc(20);
    st();
    `CHK({s[2], sc}, 2'h3)
    quiet(50);
    `CHK(hits, 0)
    lvl.vs_below_bo <= 1'b0;
    lvl.vs_above_bo <= 1'b1;
    cyc(4);
    st();
    `CHK(s[2], 1'b0)
    wait_gate(1'b1);
    lvl.die_hot <= 1'b1;
    cyc(5);
    `CHK(foff, 1'b1)
    quiet(40);
    `CHK(hits, 0)
    lvl.die_hot <= 1'b0;
    wait_gate(1'b1);
    lvl.sd_otp     <= 1'b1;
    lvl.sd_otp_rel <= 1'b0;
    cyc(5);
    st();
    `CHK({s[11], s[7:6]}, 3'h6)
    lvl.sd_otp <= 1'b0;
    quiet(150);
    `CHK(hits, 0)
    lvl.sd_otp_rel <= 1'b1;
    wait_gate(1'b1);
  endtask

  task automatic t_latch();
    c        = BASE;
    c.vcc_on = 1'b0;
    c.sd_otp = 1'b1;
    c.sd_otp_rel = 1'b0;
    lvl <= c;
    do_reset(1'b1);
    lvl.vcc_on <= 1'b1;
    cyc(8);
    st();
    `CHK(s[7:6], 2'h1)
    cyc(20);
    st();
    `CHK(s[7:6], 2'h3)
    lvl.sd_otp     <= 1'b0;
    lvl.sd_otp_rel <= 1'b1;
    quiet(150);
    st();
    `CHK({hits != 0, s[7:6]}, 3'h3)
    lvl <= BASE;
    do_reset(1'b1);
    lvl.sd_ovp <= 1'b1;
    cyc(5);
    st();
    `CHK({s[10], s[7:6]}, 3'h7)
    lvl.sd_ovp <= 1'b0;
    quiet(150);
    `CHK(hits, 0)
    do_reset(1'b1);
    lvl.vcc_ovp <= 1'b1;
    cyc(5);
    st();
    `CHK({s[12], s[7:6]}, 3'h6)
    lvl.vcc_ovp <= 1'b0;
    wait_gate(1'b1);
  endtask

  // Main sequence
  initial begin
    rst_n_i         = 1'b0;
    latch_variant_i = 1'b0;
    ring            = 1'b1;
    stop            = 1'b0;
    hsel            = 1'b0;
    hwrite          = 1'b0;
    htrans          = 2'h0;
    hsize           = 3'h2;
    haddr           = 32'h00000000;
    hwdata          = 32'h00000000;
    lvl             = BASE;
    lvl.vcc_on      = 1'b0;
    n_fail          = 0;
    tests_run       = 0;
    do_reset(1'b0);
    t_regs();
    t_lines();
    t_ilim();
    t_aux();
    t_wshort();
    t_block();
    t_latch();
    print_verdict();
  end
endmodule
